// ### pbcs_top.sv
`timescale 1ns/1ps
// What this block does
// - Switch completes after at most three edges of each source clock.
// - Base clock stays static while a source switch is in progress.
// - Selected source divided by two.
// - Select bit clear picks crystal clock, set picks VCO clock.
// - VCO clock cannot be selected while the PLL is off.
// - PLL cannot be switched off while the VCO clock is selected.
// - PLL on/off and VCO select/deselect never change in one write.
// - Zero linear multiplier disables PLL and forces the crystal clock.
// - Feedback multiplier zero behaves exactly as one.
// - Feedback divider divides VCO clock by the multiplier.
// - Reset sets PLL enable and clears the select bit.
// - Programming registers ignore writes while the PLL is enabled.
module pbcs_top (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire pbcs_pkg::pbcs_axi_req_s axi_i,
  output pbcs_pkg::pbcs_axi_rsp_s axi_o,
  input wire logic crystal_clock_i,
  input wire logic vco_clock_i,
  output logic base_clock_o,
  output logic pll_enable_o,
  output logic [1:0] vco_power_range_o,
  output logic [11:0] feedback_multiplier_o,
  output logic [7:0] vco_range_select_o,
  output logic vco_feedback_o,
  output logic source_busy_o
);

  typedef struct packed {
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    logic base_clock_select;
    logic [1:0] vco_power_range_bits;
    logic [3:0] mul_hi;
    logic [7:0] mul_lo;
    logic [7:0] vrs;
    logic [11:0] fb_cnt;
    logic fb_pulse;
  } pbcs_top_s;

  pbcs_top_s s;
  pbcs_top_s next_s;
  logic active_sel;
  logic busy;
  logic vco_rise;
  logic pll_active;
  logic [11:0] div_n;

  function automatic pbcs_pkg::pbcs_reg_e decode(input logic [11:0] addr);
    pbcs_pkg::pbcs_reg_e r;
    r = pbcs_pkg::REG_NONE;
    if (addr[1:0] != 2'h0) begin
      r = pbcs_pkg::REG_NONE;
    end else if (addr[11:2] == {2'h0, pbcs_pkg::CTRL_IDX}) begin
      r = pbcs_pkg::REG_CTRL;
    end else if (addr[11:2] == {2'h0, pbcs_pkg::MULH_IDX}) begin
      r = pbcs_pkg::REG_MULH;
    end else if (addr[11:2] == {2'h0, pbcs_pkg::MULL_IDX}) begin
      r = pbcs_pkg::REG_MULL;
    end else if (addr[11:2] == {2'h0, pbcs_pkg::RANGE_IDX}) begin
      r = pbcs_pkg::REG_RANGE;
    end else if (addr[11:2] == {2'h0, pbcs_pkg::STAT_IDX}) begin
      r = pbcs_pkg::REG_STAT;
    end
    return r;
  endfunction

  // Divide ratio with zero read as one
  function automatic logic [11:0] eff_mul(input logic [3:0] hi,
                                          input logic [7:0] lo);
    logic [11:0] m;
    m = {hi, lo};
    if (m == 12'h000) begin
      m = 12'h001;
    end
    return m;
  endfunction

  assign pll_active = s.en && (s.vrs != 8'h00);
  assign div_n = eff_mul(s.mul_hi, s.mul_lo);

  pbcs_clk_switch u_switch (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .crystal_clock_i(crystal_clock_i),
    .vco_clock_i(vco_clock_i),
    .sel_i(s.base_clock_select),
    .base_clock_o(base_clock_o),
    .active_sel_o(active_sel),
    .busy_o(busy),
    .vco_rise_o(vco_rise)
  );

  always_comb begin
    pbcs_pkg::pbcs_reg_e wsel;
    pbcs_pkg::pbcs_reg_e rsel;
    logic [7:0] d;
    logic want_en;
    logic want_sel;
    logic [7:0] rd;
    wsel = decode(s.awaddr);
    rsel = decode(axi_i.araddr);
    d = s.wdata[7:0];
    want_en = d[pbcs_pkg::CTRL_EN_BIT];
    want_sel = d[pbcs_pkg::CTRL_SEL_BIT];
    rd = 8'h00;
    next_s = s;
    next_s.fb_pulse = 1'b0;

    // Write address and data taken in either order
    if (axi_i.awvalid && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_i.awaddr;
    end
    if (axi_i.wvalid && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_i.wdata;
      next_s.wstrb = axi_i.wstrb;
    end
    if (s.bvalid && axi_i.bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = pbcs_pkg::RESP_OKAY;
      if (wsel == pbcs_pkg::REG_NONE) begin
        next_s.bresp = pbcs_pkg::RESP_SLVERR;
      end else if (s.wstrb[0]) begin
        if (wsel == pbcs_pkg::REG_CTRL) begin
          next_s.en = want_en || s.base_clock_select;
          if (next_s.en != s.en) begin
            next_s.base_clock_select = s.base_clock_select;
          end else begin
            next_s.base_clock_select = want_sel && s.en && (s.vrs != 8'h00);
          end
          if (!s.en) begin
            next_s.vco_power_range_bits = d[pbcs_pkg::CTRL_VPR_LSB +: 2];
          end
        end else if (wsel == pbcs_pkg::REG_MULH) begin
          if (!s.en) begin
            next_s.mul_hi = d[3:0];
          end
        end else if (wsel == pbcs_pkg::REG_MULL) begin
          if (!s.en) begin
            next_s.mul_lo = d;
          end
        end else if (wsel == pbcs_pkg::REG_RANGE) begin
          if (!s.en) begin
            next_s.vrs = d;
          end
        end
      end
    end

    // Zero linear multiplier keeps the crystal clock
    if (next_s.vrs == 8'h00) begin
      next_s.base_clock_select = 1'b0;
    end

    // Read channel
    if (s.rvalid && axi_i.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (axi_i.arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = pbcs_pkg::RESP_OKAY;
      if (rsel == pbcs_pkg::REG_CTRL) begin
        rd = {2'h0, s.en, s.base_clock_select, 2'h0, s.vco_power_range_bits};
      end else if (rsel == pbcs_pkg::REG_MULH) begin
        rd = {4'h0, s.mul_hi};
      end else if (rsel == pbcs_pkg::REG_MULL) begin
        rd = s.mul_lo;
      end else if (rsel == pbcs_pkg::REG_RANGE) begin
        rd = s.vrs;
      end else if (rsel == pbcs_pkg::REG_STAT) begin
        rd = {5'h00, pll_active, busy, active_sel};
      end else begin
        next_s.rresp = pbcs_pkg::RESP_SLVERR;
      end
      next_s.rdata = {24'h000000, rd};
    end

    // Feedback divider, one pulse per N VCO cycles
    if (!pll_active) begin
      next_s.fb_cnt = 12'h000;
    end else if (vco_rise) begin
      if (s.fb_cnt >= div_n - 12'h001) begin
        next_s.fb_cnt = 12'h000;
        next_s.fb_pulse = 1'b1;
      end else begin
        next_s.fb_cnt = s.fb_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.en <= pbcs_pkg::CTRL_RST[pbcs_pkg::CTRL_EN_BIT];
      s.base_clock_select <= pbcs_pkg::CTRL_RST[pbcs_pkg::CTRL_SEL_BIT];
      s.vco_power_range_bits <= pbcs_pkg::CTRL_RST[pbcs_pkg::CTRL_VPR_LSB +: 2];
      s.mul_hi <= pbcs_pkg::MULH_RST;
      s.mul_lo <= pbcs_pkg::MULL_RST;
      s.vrs <= pbcs_pkg::RANGE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign axi_o.awready = !s.aw_got;
  assign axi_o.wready = !s.w_got;
  assign axi_o.bvalid = s.bvalid;
  assign axi_o.bresp = s.bresp;
  assign axi_o.arready = !s.rvalid;
  assign axi_o.rvalid = s.rvalid;
  assign axi_o.rdata = s.rdata;
  assign axi_o.rresp = s.rresp;
  assign pll_enable_o = pll_active;
  assign vco_power_range_o = s.vco_power_range_bits;
  assign feedback_multiplier_o = div_n;
  assign vco_range_select_o = s.vrs;
  assign vco_feedback_o = s.fb_pulse;
  assign source_busy_o = busy;

  chk_sel_needs_en: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    $rose(s.base_clock_select) |-> $past(s.en))
    else $error("VCO selected while PLL was off");

  chk_en_held_sel: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    s.base_clock_select |=> s.en)
    else $error("PLL switched off while VCO selected");

  chk_no_dual_change: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    not ($changed(s.en) && $changed(s.base_clock_select)))
    else $error("enable and select changed together");

  chk_zero_range: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.vrs == 8'h00) |-> (!s.base_clock_select && !pll_enable_o))
    else $error("zero linear multiplier left PLL usable");

  chk_reset_state: assert property (
    @(posedge clock_i)
    $past(sys_rst_i) && !sys_rst_i |-> (s.en && !s.base_clock_select))
    else $error("wrong enable or select after reset");

  chk_prog_lock: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    $past(s.en) |-> ($stable(s.mul_lo) && $stable(s.vrs)
                     && $stable(s.mul_hi)))
    else $error("programming changed while PLL enabled");

  chk_fb_bound: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    s.fb_cnt < div_n)
    else $error("feedback count reached the divide ratio");

  chk_zero_is_one: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ({s.mul_hi, s.mul_lo} == 12'h000) |-> (feedback_multiplier_o == 12'h001))
    else $error("zero multiplier not treated as one");

  chk_select_follow: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !busy && $past(!busy) && (s.base_clock_select == $past(s.base_clock_select)) && $past(s.base_clock_select) ==
      $past(active_sel, 2) |-> (active_sel == $past(active_sel)))
    else $error("active source changed without a request");

  chk_src_matches: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (!busy && $stable(s.base_clock_select)) |-> (active_sel == s.base_clock_select))
    else $error("idle source differs from the select bit");

  chk_switch_starts: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ($changed(s.base_clock_select) && !busy) |=> busy)
    else $error("select change did not start a switch");

  chk_off_needs_xtal: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    $fell(s.en) |-> $past(!s.base_clock_select))
    else $error("PLL turned off while VCO was selected");

  chk_vpr_lock: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    $past(s.en) |-> $stable(s.vco_power_range_bits))
    else $error("power range bits changed while PLL enabled");

  chk_off_quiet: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !pll_active |=> (!s.fb_pulse && (s.fb_cnt == 12'h000)))
    else $error("feedback divider ran while PLL disabled");

  chk_pulse_single: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    s.fb_pulse |=> !s.fb_pulse)
    else $error("feedback pulse longer than one cycle");

  chk_pulse_wrap: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    s.fb_pulse |-> ((s.fb_cnt == 12'h000) && $past(vco_rise)))
    else $error("feedback pulse without a counter wrap");

  chk_bvalid_hold: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.bvalid && !axi_i.bready) |=> (s.bvalid && $stable(s.bresp)))
    else $error("write response dropped before it was taken");

  chk_rvalid_hold: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.rvalid && !axi_i.rready) |=>
      (s.rvalid && $stable(s.rdata) && $stable(s.rresp)))
    else $error("read data dropped before it was taken");

  chk_bad_addr_quiet: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.aw_got && s.w_got && !s.bvalid &&
      (decode(s.awaddr) == pbcs_pkg::REG_NONE)) |=>
      ($stable(s.en) && $stable(s.base_clock_select) && $stable(s.vrs)))
    else $error("write to an unmapped address changed state");

endmodule

// ### pbcs_pkg.sv
package pbcs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h36;
  localparam logic [7:0] MULH_IDX = 8'h38;
  localparam logic [7:0] MULL_IDX = 8'h39;
  localparam logic [7:0] RANGE_IDX = 8'h3a;
  localparam logic [7:0] STAT_IDX = 8'h3c;

  // Control register field positions
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_SEL_BIT = 4;
  localparam int CTRL_VPR_LSB = 0;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam logic [3:0] MULH_RST = 4'h0;
  localparam logic [7:0] MULL_RST = 8'h40;
  localparam logic [7:0] RANGE_RST = 8'h40;

  // Edges of the new source before it takes over
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_CTRL = 3'b001,
    REG_MULH = 3'b010,
    REG_MULL = 3'b011,
    REG_RANGE = 3'b100,
    REG_STAT = 3'b101
  } pbcs_reg_e;

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_GATE = 2'b01,
    SW_WAIT = 2'b10
  } pbcs_sw_e;

  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } pbcs_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pbcs_axi_rsp_s;

  typedef struct packed {
    logic xs1;
    logic xs2;
    logic xs3;
    logic vs1;
    logic vs2;
    logic vs3;
    logic cur_sel;
    pbcs_sw_e state;
    logic [1:0] cnt;
    logic base;
  } pbcs_sw_s;

endpackage

// ### pbcs_clk_switch.sv
`timescale 1ns/1ps
module pbcs_clk_switch (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic crystal_clock_i,
  input wire logic vco_clock_i,
  input wire logic sel_i,
  output logic base_clock_o,
  output logic active_sel_o,
  output logic busy_o,
  output logic vco_rise_o
);

  pbcs_pkg::pbcs_sw_s s;
  pbcs_pkg::pbcs_sw_s next_s;
  logic xr;
  logic vr;
  logic old_lvl;
  logic old_rise;
  logic new_rise;

  // Rising edges seen after the second synchroniser stage
  assign xr = s.xs2 & ~s.xs3;
  assign vr = s.vs2 & ~s.vs3;
  assign old_lvl = s.cur_sel ? s.vs2 : s.xs2;
  assign old_rise = s.cur_sel ? vr : xr;
  assign new_rise = sel_i ? vr : xr;

  always_comb begin
    next_s = s;
    next_s.xs1 = crystal_clock_i;
    next_s.xs2 = s.xs1;
    next_s.xs3 = s.xs2;
    next_s.vs1 = vco_clock_i;
    next_s.vs2 = s.vs1;
    next_s.vs3 = s.vs2;
    case (s.state)
      pbcs_pkg::SW_RUN: begin
        if (sel_i != s.cur_sel) begin
          next_s.state = pbcs_pkg::SW_GATE;
        end else if (old_rise) begin
          next_s.base = ~s.base;
        end
      end
      pbcs_pkg::SW_GATE: begin
        if (sel_i == s.cur_sel) begin
          next_s.state = pbcs_pkg::SW_RUN;
        end else if (!old_lvl) begin
          next_s.state = pbcs_pkg::SW_WAIT;
          next_s.cnt = 2'h0;
        end
      end
      pbcs_pkg::SW_WAIT: begin
        if (new_rise) begin
          if (s.cnt == pbcs_pkg::SWITCH_EDGES - 2'h1) begin
            next_s.cur_sel = sel_i;
            next_s.state = pbcs_pkg::SW_RUN;
          end else begin
            next_s.cnt = s.cnt + 2'h1;
          end
        end
      end
      default: begin
        next_s.state = pbcs_pkg::SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign base_clock_o = s.base;
  assign active_sel_o = s.cur_sel;
  assign busy_o = (s.state != pbcs_pkg::SW_RUN);
  assign vco_rise_o = vr;

  chk_hold_static: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state != pbcs_pkg::SW_RUN) |=> $stable(s.base))
    else $error("base clock moved during a source switch");

  chk_edge_count: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == pbcs_pkg::SW_WAIT) |-> (s.cnt < pbcs_pkg::SWITCH_EDGES))
    else $error("switch waited beyond three edges");

  chk_half_rate: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    $changed(s.base) |-> $past(old_rise && s.state == pbcs_pkg::SW_RUN))
    else $error("base clock toggled without a source edge");

endmodule

// ### pbcs_sim_model.sv
`timescale 1ns/1ps
module pbcs_sim_model #(
  parameter int XHALF = 41,
  parameter int VHALF = 33
) (
  input wire logic base_clock_i,
  output logic crystal_clock_o,
  output logic vco_clock_o,
  output int base_rises_o,
  output int vco_rises_o
);
  initial begin
    crystal_clock_o = 1'b0;
    vco_clock_o = 1'b0;
    base_rises_o = 0;
    vco_rises_o = 0;
  end
  // Free-running sources, unrelated in phase to the system clock
  always #(XHALF) crystal_clock_o = ~crystal_clock_o;
  always #(VHALF) vco_clock_o = ~vco_clock_o;
  // Consumer side counts base clock rises as its time base
  always @(posedge base_clock_i) base_rises_o++;
  always @(posedge vco_clock_o) vco_rises_o++;
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int XH = 41;
  localparam int VH = 33;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  pbcs_pkg::pbcs_axi_req_s axi = '0;
  pbcs_pkg::pbcs_axi_rsp_s rsp;
  logic xclk, vclk, base, en, fb, busy, pb, pbz;
  logic [1:0] vco_power_range_bits;
  logic [11:0] mul;
  logic [7:0] rng;
  int nb, nv, nf = 0, ng = 0, cyc = 0, n_mismatch = 0, n_tests = 0;

  always #4 clock_i = ~clock_i;

  pbcs_top i_pbcs_top (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .axi_i(axi),
    .axi_o(rsp),
    .crystal_clock_i(xclk),
    .vco_clock_i(vclk),
    .base_clock_o(base),
    .pll_enable_o(en),
    .vco_power_range_o(vco_power_range_bits),
    .feedback_multiplier_o(mul),
    .vco_range_select_o(rng),
    .vco_feedback_o(fb),
    .source_busy_o(busy)
  );

  pbcs_sim_model #(.XHALF(XH), .VHALF(VH)) i_pbcs_sim_model (
    .base_clock_i(base),
    .crystal_clock_o(xclk),
    .vco_clock_o(vclk),
    .base_rises_o(nb),
    .vco_rises_o(nv)
  );

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Feedback pulses, base edges while busy, hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (fb === 1'b1)
      nf++;
    if (busy === 1'b1 && pbz === 1'b1 && pb !== base)
      ng++;
    pb = base;
    pbz = busy;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  function automatic logic near(input int a, input int e);
    return a >= e - 1 && a <= e + 1;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] er = pbcs_pkg::RESP_OKAY,
                    input logic [3:0] st = 4'hf);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clock_i);
    axi.awaddr <= ad(i);
    axi.awvalid <= 1'b1;
    axi.wdata <= {24'h0, d};
    axi.wstrb <= st;
    axi.wvalid <= 1'b1;
    axi.bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clock_i);
      if (axi.awvalid && rsp.awready) begin
        a = 1'b1;
        axi.awvalid <= 1'b0;
      end
      if (axi.wvalid && rsp.wready) begin
        w = 1'b1;
        axi.wvalid <= 1'b0;
      end
    end
    do @(posedge clock_i); while (rsp.bvalid !== 1'b1);
    axi.bready <= 1'b0;
    chk(32'(rsp.bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock_i);
    axi.araddr <= ad(i);
    axi.arvalid <= 1'b1;
    axi.rready <= 1'b1;
    do @(posedge clock_i); while (rsp.arready !== 1'b1);
    axi.arvalid <= 1'b0;
    do @(posedge clock_i); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    axi.rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, e);
  endtask

  task automatic win(output int b, output int v, output int f);
    int b0, v0, f0;
    b0 = nb;
    v0 = nv;
    f0 = nf;
    repeat (400) @(posedge clock_i);
    b = nb - b0;
    v = nv - v0;
    f = nf - f0;
  endtask

  task automatic sw_wait(output int k);
    k = 0;
    repeat (100) begin
      @(posedge clock_i);
      if (busy === 1'b1)
        k++;
      else if (k > 0)
        break;
    end
  endtask

  initial begin
    logic [7:0] m, h, g, n;
    logic [1:0] e, r;
    logic [31:0] d;
    int b, v, f, k;
    void'($urandom(74));
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rc(pbcs_pkg::CTRL_IDX, 32'h20);
    rc(pbcs_pkg::MULH_IDX, 32'h0);
    rc(pbcs_pkg::MULL_IDX, 32'h40);
    rc(pbcs_pkg::RANGE_IDX, 32'h40);
    rc(pbcs_pkg::STAT_IDX, 32'h4);
    rd(8'h3b, d, r);
    chk(32'(r), 32'(pbcs_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    wr(8'h3b, 8'h00, pbcs_pkg::RESP_SLVERR);
    wr(pbcs_pkg::CTRL_IDX, 8'h00, pbcs_pkg::RESP_OKAY, 4'he);
    rc(pbcs_pkg::CTRL_IDX, 32'h20);
    wr(pbcs_pkg::MULL_IDX, 8'h07);
    rc(pbcs_pkg::MULL_IDX, 32'h40);
    win(b, v, f);
    chk(32'(near(b, 3200 / (4 * XH))), 32'h1);
    wr(pbcs_pkg::CTRL_IDX, 8'h00);
    chk(32'(en), 32'h0);
    wr(pbcs_pkg::CTRL_IDX, 8'h10);
    rc(pbcs_pkg::CTRL_IDX, 32'h0);
    repeat (3) begin
      m = 8'($urandom_range(255, 1));
      h = 8'($urandom_range(15, 0));
      g = 8'($urandom_range(255, 1));
      e = 2'($urandom_range(2, 0));
      wr(pbcs_pkg::MULL_IDX, m);
      wr(pbcs_pkg::MULH_IDX, h);
      wr(pbcs_pkg::RANGE_IDX, g);
      wr(pbcs_pkg::CTRL_IDX, {6'h0, e});
      rc(pbcs_pkg::MULH_IDX, 32'(h));
      chk(32'(mul), 32'({h[3:0], m}));
      chk(32'(rng), 32'(g));
      chk(32'(vco_power_range_bits), 32'(e));
    end
    wr(pbcs_pkg::MULL_IDX, 8'h00);
    wr(pbcs_pkg::MULH_IDX, 8'h00);
    chk(32'(mul), 32'h1);
    n = 8'($urandom_range(5, 2));
    wr(pbcs_pkg::MULL_IDX, n);
    wr(pbcs_pkg::RANGE_IDX, 8'h00);
    wr(pbcs_pkg::CTRL_IDX, 8'h20);
    chk(32'(en), 32'h0);
    wr(pbcs_pkg::CTRL_IDX, 8'h30);
    rc(pbcs_pkg::CTRL_IDX, 32'h20);
    wr(pbcs_pkg::CTRL_IDX, 8'h00);
    wr(pbcs_pkg::RANGE_IDX, 8'h45);
    wr(pbcs_pkg::CTRL_IDX, 8'h30);
    rc(pbcs_pkg::CTRL_IDX, 32'h20);
    wr(pbcs_pkg::CTRL_IDX, 8'h30);
    sw_wait(k);
    chk(32'(k > 0 && k <= 3 * 10 + 3 * 8 + 6), 32'h1);
    rc(pbcs_pkg::CTRL_IDX, 32'h30);
    rc(pbcs_pkg::STAT_IDX, 32'h5);
    win(b, v, f);
    chk(32'(near(b, 3200 / (4 * VH))), 32'h1);
    chk(32'(near(f, v / int'(n))), 32'h1);
    wr(pbcs_pkg::CTRL_IDX, 8'h10);
    rc(pbcs_pkg::CTRL_IDX, 32'h30);
    wr(pbcs_pkg::CTRL_IDX, 8'h00);
    rc(pbcs_pkg::CTRL_IDX, 32'h20);
    sw_wait(k);
    chk(32'(k > 0 && k <= 3 * 10 + 3 * 8 + 6), 32'h1);
    rc(pbcs_pkg::STAT_IDX, 32'h4);
    win(b, v, f);
    chk(32'(near(b, 3200 / (4 * XH))), 32'h1);
    chk(32'(ng), 32'h0);
    end_of_test();
  end
endmodule
